// >>> rta_rtc_alarm.sv
// Time counters with access freeze, calendar alarm and flag register
`timescale 1ns/1ps
// Function
// - Year holds two BCD digits, tens high nibble, units low nibble.
// - Time counters stop incrementing while a host access is in progress.
// - After the access, one held-back tick is applied; only one is kept.
// - Minute match: bit 7 active-low enable, BCD tens 6-4, units 3-0.
// - Hour match: bit 7 enable, bit 6 unused, PM or tens per format.
// - Day match: bit 7 enable, bit 6 unused, tens 5-4, units 3-0.
// - Weekday match: bit 7 enable, bits 6-3 unused, weekday in 2-0.
// - Only enabled match registers take part in the comparison.
// - Alarm flag sets when all enabled comparisons first match together.
// - Alarm flag stays until cleared; re-sets only on a new increment match.
// - With interrupt enable set, interrupt pin follows the alarm flag.
// - Flag writes are ANDed: zero clears, one leaves the flag.
// - Tick flag bit 5, alarm flag bit 3, countdown flag bit 2.
// - Minutes count in BCD, tens 6-4, units 3-0.
module rta_rtc_alarm (
  // Core clock, reset and enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Seconds tick from the oscillator chain
  input wire logic i_tick_1hz,
  // Host access link
  input wire logic i_lnk_clk,
  input wire logic i_lnk_sel,
  input wire logic i_lnk_valid,
  input wire logic i_lnk_wr,
  input wire logic [rta_pkg::RTA_AW-1:0] i_lnk_addr,
  input wire logic [rta_pkg::RTA_DW-1:0] i_lnk_wdata,
  output logic o_lnk_busy,
  output logic o_lnk_rvalid,
  output logic [rta_pkg::RTA_DW-1:0] o_lnk_rdata,
  // Open-drain interrupt pin
  output logic o_int_o,
  output logic o_int_oe_n
);
  import rta_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic sel_m;
    logic sel_s;
    logic req_m;
    logic req_s;
    logic req_seen;
    logic ack;
    logic tick_m;
    logic tick_s;
    logic tick_p;
    logic pend;
    logic [7:0] rdata;
    logic [7:0] ctrl1;
    logic [7:0] flags;
    rta_time_t tm;
    logic [7:0] mmatch;
    logic [7:0] hmatch;
    logic [7:0] dmatch;
    logic [7:0] wmatch;
  } rta_core_t;
  localparam rta_core_t CORE_RST = '{
    tm: '{sec: RTA_ZERO, min: RTA_ZERO, hour: RTA_ZERO, day: RTA_DAY_FIRST,
          wday: RTA_ZERO, mon: RTA_MON_FIRST, year: RTA_ZERO},
    mmatch: RTA_MATCH_RST,
    hmatch: RTA_MATCH_RST,
    dmatch: RTA_MATCH_RST,
    wmatch: RTA_MATCH_RST,
    default: '0
  };
  rta_core_t s_q;
  rta_core_t s_d;
  logic lnk_req_tgl;
  logic lnk_wr;
  logic [RTA_AW-1:0] lnk_addr;
  logic [RTA_DW-1:0] lnk_wdata;
  logic tick_rise;
  logic inc_now;
  logic host_req;
  logic match_o;
  logic match_n;
  logic af_set;
  rta_time_t tm_next;
  // ************************************************************
  // Link side
  // ************************************************************
  rta_link #(
    .ADDR_W(RTA_AW),
    .DATA_W(RTA_DW)
  ) u_link (
    .i_lnk_clk(i_lnk_clk),
    .i_rst(i_rst),
    .i_lnk_valid(i_lnk_valid),
    .i_lnk_wr(i_lnk_wr),
    .i_lnk_addr(i_lnk_addr),
    .i_lnk_wdata(i_lnk_wdata),
    .o_lnk_busy(o_lnk_busy),
    .o_lnk_rvalid(o_lnk_rvalid),
    .o_lnk_rdata(o_lnk_rdata),
    .o_req_tgl(lnk_req_tgl),
    .o_wr(lnk_wr),
    .o_addr(lnk_addr),
    .o_wdata(lnk_wdata),
    .i_ack_tgl(s_q.ack),
    .i_rdata(s_q.rdata)
  );

  // ************************************************************
  // Counter helpers
  // ************************************************************
  // Steps a BCD byte, wrapping to vmin with carry once vmax is reached
  function automatic logic [8:0] rta_bcd_step(input logic [7:0] v, input logic [7:0] vmax,
                                              input logic [7:0] vmin);
    logic [8:0] r;
    if (v >= vmax)
      r = {1'b1, vmin};
    else if (v[3:0] >= RTA_NIB_NINE)
      r = {1'b0, v[7:4] + RTA_NIB_ONE, RTA_ZERO[3:0]};
    else
      r = {1'b0, v[7:4], v[3:0] + RTA_NIB_ONE};
    return r;
  endfunction : rta_bcd_step
  // Last day of the month; year divisible by four gives a leap February
  function automatic logic [7:0] rta_month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    logic [7:0] len;
    if (yr[4])
      leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    else
      leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    if (mon == 8'h02)
      len = leap ? 8'h29 : 8'h28;
    else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
      len = 8'h30;
    else
      len = 8'h31;
    return len;
  endfunction : rta_month_len
  // One second later, with the carry rippling up to the years
  function automatic rta_time_t rta_advance(input rta_time_t t, input logic h12);
    rta_time_t n;
    logic [8:0] r;
    logic c;
    logic [7:0] hv;
    n = t;
    r = rta_bcd_step(t.sec, RTA_SEC_MAX, RTA_ZERO);
    n.sec = r[7:0];
    c = r[8];
    if (c)
    begin
      r = rta_bcd_step(t.min, RTA_MIN_MAX, RTA_ZERO);
      n.min = r[7:0];
      c = r[8];
    end
    if (c)
    begin
      if (h12)
      begin
        hv = t.hour & RTA_H12_VAL_MSK;
        if (hv == RTA_H12_LAST)
        begin
          n.hour = RTA_H12_MAX | ((t.hour ^ RTA_PM_MSK) & RTA_PM_MSK);
          c = |(t.hour & RTA_PM_MSK);
        end
        else
        begin
          r = rta_bcd_step(hv, RTA_H12_MAX, RTA_H12_FIRST);
          n.hour = r[7:0] | (t.hour & RTA_PM_MSK);
          c = 1'b0;
        end
      end
      else
      begin
        r = rta_bcd_step(t.hour, RTA_H24_MAX, RTA_ZERO);
        n.hour = r[7:0];
        c = r[8];
      end
    end
    if (c)
    begin
      r = rta_bcd_step(t.wday, RTA_WDAY_MAX, RTA_ZERO);
      n.wday = r[7:0];
      r = rta_bcd_step(t.day, rta_month_len(t.mon, t.year), RTA_DAY_FIRST);
      n.day = r[7:0];
      c = r[8];
    end
    if (c)
    begin
      r = rta_bcd_step(t.mon, RTA_MON_MAX, RTA_MON_FIRST);
      n.mon = r[7:0];
      c = r[8];
    end
    if (c)
    begin
      r = rta_bcd_step(t.year, RTA_YEAR_MAX, RTA_ZERO);
      n.year = r[7:0];
    end
    return n;
  endfunction : rta_advance
  // True when every enabled match field equals the counter and one is enabled
  function automatic logic rta_alarm_hit(input rta_time_t t, input logic [7:0] mm,
                                         input logic [7:0] hm, input logic [7:0] dm,
                                         input logic [7:0] wm);
    logic any_en;
    logic all_eq;
    any_en = ~(mm[RTA_DIS_BIT] & hm[RTA_DIS_BIT] & dm[RTA_DIS_BIT] & wm[RTA_DIS_BIT]);
    all_eq = (mm[RTA_DIS_BIT] | ((mm & RTA_MIN_MSK) == (t.min & RTA_MIN_MSK)))
           & (hm[RTA_DIS_BIT] | ((hm & RTA_HOUR_MSK) == (t.hour & RTA_HOUR_MSK)))
           & (dm[RTA_DIS_BIT] | ((dm & RTA_DAY_MSK) == (t.day & RTA_DAY_MSK)))
           & (wm[RTA_DIS_BIT] | ((wm & RTA_WDAY_MSK) == (t.wday & RTA_WDAY_MSK)));
    return any_en & all_eq;
  endfunction : rta_alarm_hit
  // Register read view; time and match registers had unused bits stripped on write, control keeps all written bits, flags all but the ANDed bits 5, 3, 2
  function automatic logic [7:0] rta_read(input rta_core_t s, input logic [RTA_AW-1:0] a);
    logic [7:0] v;
    case (a)
      RTA_A_CTRL1: v = s.ctrl1;
      RTA_A_FLAGS: v = s.flags;
      RTA_A_SEC: v = s.tm.sec;
      RTA_A_MIN: v = s.tm.min;
      RTA_A_HOUR: v = s.tm.hour;
      RTA_A_DAY: v = s.tm.day;
      RTA_A_WDAY: v = s.tm.wday;
      RTA_A_MON: v = s.tm.mon;
      RTA_A_YEAR: v = s.tm.year;
      RTA_A_MMATCH: v = s.mmatch;
      RTA_A_HMATCH: v = s.hmatch;
      RTA_A_DMATCH: v = s.dmatch;
      RTA_A_WMATCH: v = s.wmatch;
      default: v = RTA_ZERO;
    endcase
    return v;
  endfunction : rta_read
  // ************************************************************
  // Event decode
  // ************************************************************
  assign tick_rise = s_q.tick_s & ~s_q.tick_p;
  assign host_req = s_q.req_s ^ s_q.req_seen;
  assign inc_now = ~s_q.sel_s & (tick_rise | s_q.pend);
  assign tm_next = rta_advance(s_q.tm, s_q.ctrl1[RTA_H12_BIT]);
  assign match_o = rta_alarm_hit(s_q.tm, s_q.mmatch, s_q.hmatch, s_q.dmatch, s_q.wmatch);
  assign match_n = rta_alarm_hit(tm_next, s_q.mmatch, s_q.hmatch, s_q.dmatch, s_q.wmatch);
  assign af_set = inc_now & match_n & ~match_o;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.sel_m = i_lnk_sel;
    s_d.sel_s = s_q.sel_m;
    s_d.req_m = lnk_req_tgl;
    s_d.req_s = s_q.req_m;
    s_d.tick_m = i_tick_1hz;
    s_d.tick_s = s_q.tick_m;
    s_d.tick_p = s_q.tick_s;
    s_d.pend = s_q.sel_s ? (s_q.pend | tick_rise) : (s_q.pend & tick_rise);
    if (inc_now)
      s_d.tm = tm_next;
    if (host_req)
    begin
      s_d.req_seen = s_q.req_s;
      s_d.ack = ~s_q.ack;
      s_d.rdata = rta_read(s_q, lnk_addr);
      if (lnk_wr)
      begin
        case (lnk_addr)
          RTA_A_CTRL1: s_d.ctrl1 = lnk_wdata;
          RTA_A_FLAGS: s_d.flags = (lnk_wdata & ~RTA_FLAG_MASK)
                                 | (lnk_wdata & s_q.flags & RTA_FLAG_MASK);
          RTA_A_SEC: s_d.tm.sec = lnk_wdata & RTA_SEC_MSK;
          RTA_A_MIN: s_d.tm.min = lnk_wdata & RTA_MIN_MSK;
          RTA_A_HOUR: s_d.tm.hour = lnk_wdata & RTA_HOUR_MSK;
          RTA_A_DAY: s_d.tm.day = lnk_wdata & RTA_DAY_MSK;
          RTA_A_WDAY: s_d.tm.wday = lnk_wdata & RTA_WDAY_MSK;
          RTA_A_MON: s_d.tm.mon = lnk_wdata & RTA_MON_MSK;
          RTA_A_YEAR: s_d.tm.year = lnk_wdata & RTA_YEAR_MSK;
          RTA_A_MMATCH: s_d.mmatch = lnk_wdata & (RTA_EN_MSK | RTA_MIN_MSK);
          RTA_A_HMATCH: s_d.hmatch = lnk_wdata & (RTA_EN_MSK | RTA_HOUR_MSK);
          RTA_A_DMATCH: s_d.dmatch = lnk_wdata & (RTA_EN_MSK | RTA_DAY_MSK);
          RTA_A_WMATCH: s_d.wmatch = lnk_wdata & (RTA_EN_MSK | RTA_WDAY_MSK);
          default: s_d.rdata = RTA_ZERO;
        endcase
      end
    end
    // set wins over a clearing write
    if (af_set)
      s_d.flags[RTA_AF_BIT] = 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      s_q <= CORE_RST;
    else if (i_clk_en)
      s_q <= s_d;
  end

  // ************************************************************
  // Interrupt pin
  // ************************************************************
  assign o_int_o = 1'b0;
  assign o_int_oe_n = ~(s_q.flags[RTA_AIE_BIT] & s_q.flags[RTA_AF_BIT]);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst || !i_clk_en);

  a_freeze_time: assert property ((s_q.sel_s && !host_req) |=> $stable(s_q.tm))
    else $error("time changed during access");
  a_pend_serviced: assert property ((!s_q.sel_s && s_q.pend) |=>
    (s_q.tm.sec != $past(s_q.tm.sec)))
    else $error("pending tick not applied");
  a_pend_held: assert property ((s_q.sel_s && tick_rise) |=> s_q.pend)
    else $error("tick during access lost");
  a_year_store: assert property ((host_req && lnk_wr && lnk_addr == RTA_A_YEAR
    && !inc_now) |=> (s_q.tm.year == $past(lnk_wdata)))
    else $error("year write not stored");
  a_min_wrap: assert property ((inc_now && s_q.tm.sec == RTA_SEC_MAX
    && s_q.tm.min == RTA_MIN_MAX) |=> (s_q.tm.min == RTA_ZERO))
    else $error("minutes did not wrap");
  a_alarm_set: assert property (af_set |=> s_q.flags[RTA_AF_BIT])
    else $error("alarm flag not set");
  a_alarm_cause: assert property ($rose(s_q.flags[RTA_AF_BIT]) |-> $past(inc_now))
    else $error("alarm flag set without increment");
  a_all_disabled: assert property ((s_q.mmatch[RTA_DIS_BIT] && s_q.hmatch[RTA_DIS_BIT]
    && s_q.dmatch[RTA_DIS_BIT] && s_q.wmatch[RTA_DIS_BIT]) |-> !af_set)
    else $error("alarm with all matches disabled");
  a_flag_and: assert property ((host_req && lnk_wr && lnk_addr == RTA_A_FLAGS
    && !af_set) |=> ((s_q.flags & RTA_FLAG_MASK) ==
    ($past(s_q.flags) & $past(lnk_wdata) & RTA_FLAG_MASK)))
    else $error("flag write not ANDed");
  a_int_follow: assert property ((s_q.flags[RTA_AIE_BIT] && af_set) |=> !o_int_oe_n)
    else $error("interrupt not following alarm flag");

  c_alarm_rise: cover property ($rose(s_q.flags[RTA_AF_BIT]));
  c_pend_used: cover property ($fell(s_q.sel_s) && s_q.pend);
  c_flag_clear: cover property ($fell(s_q.flags[RTA_AF_BIT]));
  c_day_roll: cover property (inc_now && tm_next.day == RTA_DAY_FIRST && tm_next.sec == RTA_ZERO);

endmodule : rta_rtc_alarm

// >>> rta_pkg.sv
// Constants, field layouts and types shared by the alarm and time access block
package rta_pkg;

  // ************************************************************
  // Bus widths
  // ************************************************************
  localparam int RTA_AW = 4;
  localparam int RTA_DW = 8;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] RTA_A_CTRL1 = 4'h0;
  localparam logic [3:0] RTA_A_FLAGS = 4'h1;
  localparam logic [3:0] RTA_A_SEC = 4'h2;
  localparam logic [3:0] RTA_A_MIN = 4'h3;
  localparam logic [3:0] RTA_A_HOUR = 4'h4;
  localparam logic [3:0] RTA_A_DAY = 4'h5;
  localparam logic [3:0] RTA_A_WDAY = 4'h6;
  localparam logic [3:0] RTA_A_MON = 4'h7;
  localparam logic [3:0] RTA_A_YEAR = 4'h8;
  localparam logic [3:0] RTA_A_MMATCH = 4'h9;
  localparam logic [3:0] RTA_A_HMATCH = 4'hA;
  localparam logic [3:0] RTA_A_DMATCH = 4'hB;
  localparam logic [3:0] RTA_A_WMATCH = 4'hC;

  // ************************************************************
  // Bit positions and field masks
  // ************************************************************
  localparam int RTA_DIS_BIT = 7;
  localparam int RTA_MSF_BIT = 5;
  localparam int RTA_AF_BIT = 3;
  localparam int RTA_TF_BIT = 2;
  localparam int RTA_AIE_BIT = 1;
  localparam int RTA_H12_BIT = 2;
  localparam logic [7:0] RTA_FLAG_MASK = 8'h2C;
  localparam logic [7:0] RTA_PM_MSK = 8'h20;
  localparam logic [7:0] RTA_SEC_MSK = 8'h7F;
  localparam logic [7:0] RTA_MIN_MSK = 8'h7F;
  localparam logic [7:0] RTA_HOUR_MSK = 8'h3F;
  localparam logic [7:0] RTA_H12_VAL_MSK = 8'h1F;
  localparam logic [7:0] RTA_DAY_MSK = 8'h3F;
  localparam logic [7:0] RTA_WDAY_MSK = 8'h07;
  localparam logic [7:0] RTA_MON_MSK = 8'h1F;
  localparam logic [7:0] RTA_YEAR_MSK = 8'hFF;
  localparam logic [7:0] RTA_EN_MSK = 8'h80;

  // ************************************************************
  // Counter limits in BCD and reset values
  // ************************************************************
  localparam logic [7:0] RTA_SEC_MAX = 8'h59;
  localparam logic [7:0] RTA_MIN_MAX = 8'h59;
  localparam logic [7:0] RTA_H24_MAX = 8'h23;
  localparam logic [7:0] RTA_H12_MAX = 8'h12;
  localparam logic [7:0] RTA_H12_LAST = 8'h11;
  localparam logic [7:0] RTA_H12_FIRST = 8'h01;
  localparam logic [7:0] RTA_WDAY_MAX = 8'h06;
  localparam logic [7:0] RTA_MON_MAX = 8'h12;
  localparam logic [7:0] RTA_YEAR_MAX = 8'h99;
  localparam logic [7:0] RTA_DAY_FIRST = 8'h01;
  localparam logic [7:0] RTA_MON_FIRST = 8'h01;
  localparam logic [7:0] RTA_ZERO = 8'h00;
  localparam logic [7:0] RTA_MATCH_RST = 8'h80;
  localparam logic [3:0] RTA_NIB_NINE = 4'h9;
  localparam logic [3:0] RTA_NIB_ONE = 4'h1;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] mon;
    logic [7:0] year;
  } rta_time_t;

  typedef enum logic [1:0] {
    RTA_LK_IDLE = 2'b01,
    RTA_LK_WAIT = 2'b10
  } rta_lk_state_t;

endpackage : rta_pkg

// >>> rta_link.sv
// Link-clock side of the register access: takes bytes and hands them to the core
`timescale 1ns/1ps
module rta_link #(
  parameter int ADDR_W = rta_pkg::RTA_AW,
  parameter int DATA_W = rta_pkg::RTA_DW
) (
  // Link clock and reset
  input wire logic i_lnk_clk,
  input wire logic i_rst,
  // Access requests from the host
  input wire logic i_lnk_valid,
  input wire logic i_lnk_wr,
  input wire logic [ADDR_W-1:0] i_lnk_addr,
  input wire logic [DATA_W-1:0] i_lnk_wdata,
  output logic o_lnk_busy,
  output logic o_lnk_rvalid,
  output logic [DATA_W-1:0] o_lnk_rdata,
  // Handshake toward the core domain
  output logic o_req_tgl,
  output logic o_wr,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  input wire logic i_ack_tgl,
  input wire logic [DATA_W-1:0] i_rdata
);
  import rta_pkg::*;

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (ADDR_W != RTA_AW || DATA_W != RTA_DW)
  begin : g_bad_width
    $error("rta_link supports only the register file widths");
  end

  typedef struct packed {
    rta_lk_state_t state;
    logic req;
    logic ack_m;
    logic ack_s;
    logic ack_seen;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } rta_link_t;

  localparam rta_link_t LINK_RST = '{state: RTA_LK_IDLE, default: '0};

  rta_link_t l_q;
  rta_link_t l_d;

  // ************************************************************
  // Request capture and answer
  // ************************************************************
  always_comb
  begin
    l_d = l_q;
    l_d.rvalid = 1'b0;
    l_d.ack_m = i_ack_tgl;
    l_d.ack_s = l_q.ack_m;
    unique case (l_q.state)
      RTA_LK_IDLE:
      begin
        if (i_lnk_valid)
        begin
          l_d.wr = i_lnk_wr;
          l_d.addr = i_lnk_addr;
          l_d.wdata = i_lnk_wdata;
          l_d.req = ~l_q.req;
          l_d.state = RTA_LK_WAIT;
        end
      end
      RTA_LK_WAIT:
      begin
        // Core answer word is held stable once its toggle is seen
        if (l_q.ack_s != l_q.ack_seen)
        begin
          l_d.ack_seen = l_q.ack_s;
          l_d.rdata = i_rdata;
          l_d.rvalid = 1'b1;
          l_d.state = RTA_LK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_lnk_clk or posedge i_rst)
  begin
    if (i_rst)
      l_q <= LINK_RST;
    else
      l_q <= l_d;
  end

  assign o_lnk_busy = (l_q.state == RTA_LK_WAIT);
  assign o_lnk_rvalid = l_q.rvalid;
  assign o_lnk_rdata = l_q.rdata;
  assign o_req_tgl = l_q.req;
  assign o_wr = l_q.wr;
  assign o_addr = l_q.addr;
  assign o_wdata = l_q.wdata;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_link_take: assert property (@(posedge i_lnk_clk) disable iff (i_rst)
    (!o_lnk_busy && i_lnk_valid) |=> (o_lnk_busy && (o_req_tgl != $past(o_req_tgl))))
    else $error("link request not taken");
  a_link_answer: assert property (@(posedge i_lnk_clk) disable iff (i_rst)
    $rose(o_lnk_busy) |-> ##[1:20] o_lnk_rvalid)
    else $error("link answer too late");
  c_link_answer: cover property (@(posedge i_lnk_clk) disable iff (i_rst) o_lnk_rvalid);

endmodule : rta_link

// >>> rta_host.sv
// Host model: drives register accesses and the link clock within frames
`timescale 1ns/1ps
module rta_host (
  // Link clock and select
  output logic o_lnk_clk,
  output logic o_lnk_sel,
  // Request and answer
  output logic o_lnk_valid,
  output logic o_lnk_wr,
  output logic [3:0] o_lnk_addr,
  output logic [7:0] o_lnk_wdata,
  input wire logic i_lnk_busy,
  input wire logic i_lnk_rvalid,
  input wire logic [7:0] i_lnk_rdata
);
  // ********************
  // Clock and accesses
  // ********************
  logic run = 1'b0;
  int n;
  int late = 0;
  initial
  begin
    o_lnk_clk = 1'b0;
    o_lnk_sel = 1'b0;
    o_lnk_valid = 1'b0;
    o_lnk_wr = 1'b0;
    o_lnk_addr = 4'h0;
    o_lnk_wdata = 8'h00;
    #7.3;
    forever #24 if (run) o_lnk_clk = ~o_lnk_clk;
  end
  task automatic open_frame();
    o_lnk_sel = 1'b1;
    run = 1'b1;
    repeat (4) @(posedge o_lnk_clk);
  endtask : open_frame
  task automatic close_frame();
    @(posedge o_lnk_clk);
    #1 o_lnk_sel = 1'b0;
    run = 1'b0;
  endtask : close_frame
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    #1;
    while (i_lnk_busy !== 1'b0)
    begin
      @(posedge o_lnk_clk);
      #1;
    end
    o_lnk_valid = 1'b1;
    o_lnk_wr = wr;
    o_lnk_addr = a;
    o_lnk_wdata = d;
    // Busy was low before this edge, so the request is taken here
    @(posedge o_lnk_clk);
    #1;
    o_lnk_valid = 1'b0;
    o_lnk_wr = ~wr;
    o_lnk_addr = ~a;
    o_lnk_wdata = ~d;
    n = 0;
    do
    begin
      @(posedge o_lnk_clk);
      #1;
      n++;
    end
    while (i_lnk_rvalid !== 1'b1 && n < 20);
    if (i_lnk_rvalid !== 1'b1)
      late++;
    rd = i_lnk_rdata;
  endtask : xfer
endmodule : rta_host

// >>> tb.sv
// Testbench for the alarm and time access block
`timescale 1ns/1ps
module tb;
  import rta_pkg::*;
  // ********************
  // Signals and instances
  // ********************
  logic i_ref_clk, i_rst, i_clk_en, i_tick_1hz, i_lnk_clk, i_lnk_sel, i_lnk_valid;
  logic i_lnk_wr, o_lnk_busy, o_lnk_rvalid, o_int_o, o_int_oe_n;
  logic [3:0] i_lnk_addr;
  logic [7:0] i_lnk_wdata, o_lnk_rdata, rd;
  int err_total, check_count;
  always #10 i_ref_clk = ~i_ref_clk;
  rta_rtc_alarm rta_rtc_alarm_inst (.i_ref_clk, .i_rst, .i_clk_en, .i_tick_1hz, .i_lnk_clk,
    .i_lnk_sel, .i_lnk_valid, .i_lnk_wr, .i_lnk_addr, .i_lnk_wdata, .o_lnk_busy,
    .o_lnk_rvalid, .o_lnk_rdata, .o_int_o, .o_int_oe_n);
  rta_host rta_host_inst (.o_lnk_clk(i_lnk_clk), .o_lnk_sel(i_lnk_sel),
    .o_lnk_valid(i_lnk_valid), .o_lnk_wr(i_lnk_wr), .o_lnk_addr(i_lnk_addr),
    .o_lnk_wdata(i_lnk_wdata), .i_lnk_busy(o_lnk_busy), .i_lnk_rvalid(o_lnk_rvalid),
    .i_lnk_rdata(o_lnk_rdata));
  // ********************
  // Helpers
  // ********************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    rta_host_inst.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
    rta_host_inst.xfer(1'b0, a, exp, rd);
    chk(what, exp, rd);
  endtask : rc
  task automatic tick();
    @(negedge i_ref_clk) i_tick_1hz = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    i_tick_1hz = 1'b0;
    repeat (6) @(negedge i_ref_clk);
  endtask : tick
  // ********************
  // Scenarios
  // ********************
  task automatic test_regs();
    rta_host_inst.open_frame();
    rc("mmatch rst", RTA_A_MMATCH, 8'h80);
    rc("hmatch rst", RTA_A_HMATCH, 8'h80);
    rc("dmatch rst", RTA_A_DMATCH, 8'h80);
    rc("wmatch rst", RTA_A_WMATCH, 8'h80);
    wr(RTA_A_YEAR, 8'h99);
    rc("year", RTA_A_YEAR, 8'h99);
    wr(RTA_A_MMATCH, 8'hFF);
    rc("mmatch", RTA_A_MMATCH, 8'hFF);
    wr(RTA_A_HMATCH, 8'hFF);
    rc("hmatch", RTA_A_HMATCH, 8'hBF);
    wr(RTA_A_DMATCH, 8'hFF);
    rc("dmatch", RTA_A_DMATCH, 8'hBF);
    wr(RTA_A_WMATCH, 8'hFF);
    rc("wmatch", RTA_A_WMATCH, 8'h87);
    wr(4'hD, 8'h5A);
    rc("unmapped", 4'hD, 8'h00);
    rta_host_inst.close_frame();
    $display("test_regs done");
  endtask : test_regs
  task automatic test_freeze();
    rta_host_inst.open_frame();
    wr(RTA_A_SEC, 8'h10);
    tick();
    tick();
    rc("sec frozen", RTA_A_SEC, 8'h10);
    rta_host_inst.close_frame();
    repeat (10) @(negedge i_ref_clk);
    rta_host_inst.open_frame();
    rc("sec one pending", RTA_A_SEC, 8'h11);
    rta_host_inst.close_frame();
    $display("test_freeze done");
  endtask : test_freeze
  task automatic test_alarm();
    rta_host_inst.open_frame();
    wr(RTA_A_SEC, 8'h59);
    wr(RTA_A_MIN, 8'h05);
    wr(RTA_A_HOUR, 8'h00);
    wr(RTA_A_MMATCH, 8'h06);
    wr(RTA_A_HMATCH, 8'h85);
    wr(RTA_A_DMATCH, 8'h80);
    wr(RTA_A_WMATCH, 8'h80);
    wr(RTA_A_FLAGS, 8'h02);
    rc("flags idle", RTA_A_FLAGS, 8'h02);
    rta_host_inst.close_frame();
    tick();
    chk("irq on", 8'h00, {7'h00, o_int_oe_n});
    chk("irq level", 8'h00, {7'h00, o_int_o});
    rta_host_inst.open_frame();
    rc("minutes", RTA_A_MIN, 8'h06);
    rc("flags set", RTA_A_FLAGS, 8'h0A);
    wr(RTA_A_FLAGS, 8'h2E);
    rc("flags kept", RTA_A_FLAGS, 8'h0A);
    wr(RTA_A_FLAGS, 8'h26);
    rc("flags clear", RTA_A_FLAGS, 8'h02);
    rta_host_inst.close_frame();
    tick();
    chk("irq off", 8'h01, {7'h00, o_int_oe_n});
    rta_host_inst.open_frame();
    rc("no re-set", RTA_A_FLAGS, 8'h02);
    rta_host_inst.close_frame();
    $display("test_alarm done");
  endtask : test_alarm
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    i_ref_clk = 1'b0;
    i_rst = 1'b0;
    i_clk_en = 1'b1;
    i_tick_1hz = 1'b0;
    err_total = 0;
    check_count = 0;
    // A real rising edge so the stopped link side also resets
    #1;
    i_rst = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    test_regs();
    test_freeze();
    test_alarm();
    chk("late answers", 8'h00, rta_host_inst.late[7:0]);
    final_report();
  end
  initial
  begin
    #500000;
    err_total++;
    final_report();
  end
endmodule : tb
